// *** hw/sep_core.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sep_map.svh"

module sep_core #(
  parameter int unsigned P_TW_CYCLES = `SEP_TW_NS / `SEP_CLK_NS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        factory_rstn_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [2:0]  logical_select_address_i,
  input  wire logic        select_pin_zero_hv_i,
  input  wire logic [15:0] sens_rdata_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             busy_o,
  output logic             half_sel_o,
  output logic [3:0]       block_protect_o,
  output logic             sens_wr_o,
  output logic [7:0]       sens_ptr_o,
  output logic [15:0]      sens_wdata_o
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_m_q, rst_n;
  logic fac_m_q, fac_n;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge factory_rstn_i) begin
    if (!factory_rstn_i) begin
      fac_m_q <= 1'b0;
      fac_n   <= 1'b0;
    end else begin
      fac_m_q <= 1'b1;
      fac_n   <= fac_m_q;
    end
  end

  sep_evt_if ev ();

  sep_bus_front u_front (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .hv_i    (select_pin_zero_hv_i),
    .lsa_i   (logical_select_address_i),
    .evt     (ev.front)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  sep_pkg::sep_state_e st_q, nxt_q, nxt_d;
  sep_pkg::sep_tgt_e   tgt_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  shift_q, tx_q, addr_q;
  logic [3:0]  page_q;
  logic [2:0]  code_q;
  logic        rw_q, cmd_ok_q, mack_q, from_data_q, slot10_q;
  logic        sda_oe_n_q, ack_d;
  logic        half_q, busy_q;
  logic [3:0]  prot_q;
  logic [1:0]  sbyte_q;
  logic [23:0] tw_cnt_q;
  logic [7:0]  mem_q [`SEP_MEM_WORDS];
  logic [7:0]  wbuf_q [`SEP_PAGE_BYTES];
  logic [15:0] wval_q;

  // block index of a protection command code
  function automatic logic [2:0] code_blk(input logic [2:0] c);
    case (c)
      `SEP_CODE_BLK0: code_blk = 3'h4;
      `SEP_CODE_BLK1: code_blk = 3'h5;
      `SEP_CODE_BLK2: code_blk = 3'h6;
      `SEP_CODE_BLK3: code_blk = 3'h7;
      default:        code_blk = 3'h0;
    endcase
  endfunction : code_blk

  // acknowledge decision for a command select byte
  function automatic logic cmd_ok(input logic [2:0] c, input logic rw,
                                  input logic hv, input logic [3:0] p,
                                  input logic h);
    logic [2:0] b;
    b = code_blk(c);
    if (rw) begin
      if (c == `SEP_CODE_LOWER) cmd_ok = ~h;
      else cmd_ok = b[2] & ~p[b[1:0]];
    end else if (c == `SEP_CODE_LOWER || c == `SEP_CODE_UPPER) begin
      cmd_ok = 1'b1;
    end else begin
      cmd_ok = hv & (b[2] | (c == `SEP_CODE_CLEAR));
    end
  endfunction : cmd_ok

  logic [3:0] dtype;
  logic       lsa_hit, byte_end, tx_load, tx_shift, commit;
  logic [1:0] wr_blk;
  logic [2:0] cblk;
  assign dtype    = shift_q[7:4];
  assign lsa_hit  = shift_q[3:1] == ev.logical_select_address;
  assign wr_blk   = {half_q, page_q[3]};
  assign byte_end = ev.fall && bcnt_q == 4'h8 &&
                    (st_q == sep_pkg::S_DEV || st_q == sep_pkg::S_ADDR ||
                     st_q == sep_pkg::S_DATA);
  assign commit   = ev.stop && slot10_q;
  assign cblk     = code_blk(code_q);

  // ****************************************************************
  // acknowledge decision
  // ****************************************************************
  always_comb begin
    ack_d = 1'b0;
    nxt_d = sep_pkg::S_IDLE;
    case (st_q)
      sep_pkg::S_DEV: begin
        case (dtype)
          `SEP_DEV_MEM: begin
            ack_d = lsa_hit && !busy_q;
            nxt_d = shift_q[0] ? sep_pkg::S_TX : sep_pkg::S_ADDR;
          end
          `SEP_DEV_CMD: begin
            ack_d = !busy_q &&
                    cmd_ok(shift_q[3:1], shift_q[0], ev.hv, prot_q, half_q);
            nxt_d = sep_pkg::S_ADDR;
          end
          `SEP_DEV_SENS: begin
            ack_d = lsa_hit && !ev.hv;
            nxt_d = shift_q[0] ? sep_pkg::S_TX : sep_pkg::S_ADDR;
          end
          default: ack_d = 1'b0;
        endcase
      end
      sep_pkg::S_ADDR: begin
        ack_d = (tgt_q != sep_pkg::T_CMD) || cmd_ok_q;
        nxt_d = sep_pkg::S_DATA;
      end
      sep_pkg::S_DATA: begin
        case (tgt_q)
          sep_pkg::T_MEM:  ack_d = !prot_q[wr_blk];
          sep_pkg::T_SENS: ack_d = sbyte_q != `SEP_SENS_BYTES;
          sep_pkg::T_CMD:  ack_d = cmd_ok_q;
          default:         ack_d = 1'b0;
        endcase
        nxt_d = sep_pkg::S_DATA;
      end
      default: ack_d = 1'b0;
    endcase
  end

  // ****************************************************************
  // bit and byte sequencing
  // ****************************************************************
  assign tx_shift = ev.fall &&
    ((st_q == sep_pkg::S_ACK && nxt_q == sep_pkg::S_TX) ||
     (st_q == sep_pkg::S_TX && bcnt_q != 4'h8) ||
     (st_q == sep_pkg::S_RACK && mack_q));

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= sep_pkg::S_IDLE;
      nxt_q       <= sep_pkg::S_IDLE;
      bcnt_q      <= 4'h0;
      shift_q     <= 8'h00;
      sda_oe_n_q  <= 1'b1;
      mack_q      <= 1'b0;
      from_data_q <= 1'b0;
    end else if (ev.start) begin
      st_q       <= sep_pkg::S_DEV;
      bcnt_q     <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (ev.stop) begin
      st_q       <= sep_pkg::S_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (st_q)
        sep_pkg::S_DEV, sep_pkg::S_ADDR, sep_pkg::S_DATA: begin
          if (ev.rise && bcnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], ev.sda};
            bcnt_q  <= bcnt_q + 4'h1;
          end else if (byte_end) begin
            bcnt_q      <= 4'h0;
            nxt_q       <= nxt_d;
            from_data_q <= st_q == sep_pkg::S_DATA;
            if (ack_d) begin
              sda_oe_n_q <= 1'b0;
              st_q       <= sep_pkg::S_ACK;
            end else begin
              st_q <= sep_pkg::S_IDLE;
            end
          end
        end
        sep_pkg::S_ACK: begin
          if (ev.fall) begin
            st_q <= nxt_q;
            if (nxt_q == sep_pkg::S_TX) begin
              sda_oe_n_q <= tx_q[7];
              bcnt_q     <= 4'h1;
            end else begin
              sda_oe_n_q <= 1'b1;
            end
          end
        end
        sep_pkg::S_TX: begin
          if (ev.fall && bcnt_q == 4'h8) begin
            sda_oe_n_q <= 1'b1;
            st_q       <= sep_pkg::S_RACK;
          end else if (ev.fall) begin
            sda_oe_n_q <= tx_q[7];
            bcnt_q     <= bcnt_q + 4'h1;
          end
        end
        sep_pkg::S_RACK: begin
          if (ev.rise) begin
            mack_q <= ~ev.sda;
          end else if (ev.fall && mack_q) begin
            st_q       <= sep_pkg::S_TX;
            sda_oe_n_q <= tx_q[7];
            bcnt_q     <= 4'h1;
          end else if (ev.fall) begin
            st_q <= sep_pkg::S_IDLE;
          end
        end
        default: st_q <= sep_pkg::S_IDLE;
      endcase
    end
  end

  // transaction attributes latched from the select byte
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tgt_q    <= sep_pkg::T_NONE;
      rw_q     <= 1'b0;
      code_q   <= 3'h0;
      cmd_ok_q <= 1'b0;
    end else if (byte_end && st_q == sep_pkg::S_DEV) begin
      rw_q     <= shift_q[0];
      code_q   <= shift_q[3:1];
      cmd_ok_q <= ack_d;
      case (dtype)
        `SEP_DEV_MEM:  tgt_q <= sep_pkg::T_MEM;
        `SEP_DEV_CMD:  tgt_q <= sep_pkg::T_CMD;
        `SEP_DEV_SENS: tgt_q <= sep_pkg::T_SENS;
        default:       tgt_q <= sep_pkg::T_NONE;
      endcase
    end
  end

  // tenth slot: after an acked data byte, until the next clock fall;
  // a stop needs scl high, so the slot must span the tenth rise
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot10_q <= 1'b0;
    end else if (ev.start || ev.stop) begin
      slot10_q <= 1'b0;
    end else if (st_q == sep_pkg::S_ACK && ev.fall && from_data_q &&
                 !rw_q) begin
      slot10_q <= 1'b1;
    end else if (ev.fall) begin
      slot10_q <= 1'b0;
    end
  end

  // ****************************************************************
  // read data and address counter
  // ****************************************************************
  assign tx_load = (byte_end && st_q == sep_pkg::S_DEV && ack_d &&
                    nxt_d == sep_pkg::S_TX) ||
                   (st_q == sep_pkg::S_RACK && ev.rise && !ev.sda);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
    end else if (tx_load && (dtype == `SEP_DEV_SENS ||
                 (st_q == sep_pkg::S_RACK && tgt_q == sep_pkg::T_SENS))) begin
      // high byte after the select, then alternating per acked byte
      tx_q <= (st_q == sep_pkg::S_RACK && sbyte_q[0]) ?
              sens_rdata_i[7:0] : sens_rdata_i[15:8];
    end else if (tx_load) begin
      tx_q <= mem_q[{half_q, addr_q}];
    end else if (tx_shift) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // counter wraps inside the selected half
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `SEP_ADDR_RST;
      page_q <= 4'h0;
    end else if (byte_end && st_q == sep_pkg::S_ADDR &&
                 tgt_q == sep_pkg::T_MEM) begin
      addr_q <= shift_q;
      page_q <= shift_q[7:4];
    end else if (byte_end && st_q == sep_pkg::S_DATA &&
                 tgt_q == sep_pkg::T_MEM && ack_d) begin
      addr_q <= addr_q + 8'h01;
    end else if (tx_load && !(dtype == `SEP_DEV_SENS ||
                 (st_q == sep_pkg::S_RACK && tgt_q == sep_pkg::T_SENS))) begin
      addr_q <= addr_q + 8'h01;
    end
  end

  // ****************************************************************
  // page buffer and array
  // ****************************************************************
  // bytes wait here so a misplaced stop leaves the array untouched
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wval_q <= 16'h0000;
    end else if (byte_end && st_q == sep_pkg::S_DEV) begin
      wval_q <= 16'h0000;
    end else if (byte_end && st_q == sep_pkg::S_DATA &&
                 tgt_q == sep_pkg::T_MEM && ack_d) begin
      wval_q[addr_q[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (byte_end && st_q == sep_pkg::S_DATA && tgt_q == sep_pkg::T_MEM &&
        ack_d) begin
      wbuf_q[addr_q[3:0]] <= shift_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge fac_n) begin
    if (!fac_n) begin
      for (int i = 0; i < `SEP_MEM_WORDS; i++) begin
        mem_q[i] <= `SEP_ERASED;
      end
    end else if (commit && tgt_q == sep_pkg::T_MEM) begin
      for (int j = 0; j < `SEP_PAGE_BYTES; j++) begin
        if (wval_q[j]) begin
          mem_q[{half_q, page_q, j[3:0]}] <= wbuf_q[j];
        end
      end
    end
  end

  // ****************************************************************
  // protection, half select, programming timer
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge fac_n) begin
    if (!fac_n) begin
      prot_q <= 4'h0;
    end else if (commit && tgt_q == sep_pkg::T_CMD) begin
      if (code_q == `SEP_CODE_CLEAR) begin
        prot_q <= 4'h0;
      end else if (cblk != 3'h0) begin
        prot_q[cblk[1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else if (byte_end && st_q == sep_pkg::S_DEV && ack_d &&
                 dtype == `SEP_DEV_CMD && !shift_q[0] &&
                 shift_q[3:2] == 2'h3) begin
      half_q <= shift_q[1];
    end
  end

  // a cleared protection setting is applied only on a valid stop
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_q   <= 1'b0;
      tw_cnt_q <= 24'h000000;
    end else if (commit && (tgt_q == sep_pkg::T_MEM ||
                 (tgt_q == sep_pkg::T_CMD && code_q[2:1] != 2'h3))) begin
      busy_q   <= 1'b1;
      tw_cnt_q <= 24'(P_TW_CYCLES - 1);
    end else if (busy_q && tw_cnt_q == 24'h000000) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      tw_cnt_q <= tw_cnt_q - 24'h000001;
    end
  end

  // ****************************************************************
  // sensor register port
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sbyte_q      <= 2'h0;
      sens_ptr_o   <= 8'h00;
      sens_wdata_o <= 16'h0000;
      sens_wr_o    <= 1'b0;
    end else begin
      sens_wr_o <= commit && tgt_q == sep_pkg::T_SENS &&
                   sbyte_q == `SEP_SENS_BYTES;
      if (byte_end && st_q == sep_pkg::S_DEV) begin
        // read select starts odd so the next load takes the low byte
        sbyte_q <= {1'b0, shift_q[0]};
      end else if (tx_load && tgt_q == sep_pkg::T_SENS) begin
        sbyte_q <= {1'b0, ~sbyte_q[0]};
      end else if (byte_end && tgt_q == sep_pkg::T_SENS && ack_d) begin
        if (st_q == sep_pkg::S_ADDR) begin
          sens_ptr_o <= shift_q;
        end else if (st_q == sep_pkg::S_DATA) begin
          sbyte_q <= sbyte_q + 2'h1;
          if (sbyte_q == 2'h0) sens_wdata_o[15:8] <= shift_q;
          else sens_wdata_o[7:0] <= shift_q;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_o           <= 1'b0;
      sda_oe_n_o      <= 1'b1;
      busy_o          <= 1'b0;
      half_sel_o      <= 1'b0;
    end else begin
      sda_o           <= 1'b0;
      sda_oe_n_o      <= sda_oe_n_q;
      busy_o          <= busy_q;
      half_sel_o      <= half_q;
    end
  end

  // protection is nonvolatile, so its copy ignores power-on reset
  always_ff @(posedge sys_clk_i or negedge fac_n) begin
    if (!fac_n) begin
      block_protect_o <= 4'h0;
    end else begin
      block_protect_o <= prot_q;
    end
  end

endmodule : sep_core

`default_nettype wire

// *** hw/sep_map.svh ***
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

// ****************************************************************
// select byte type codes
// ****************************************************************
`define SEP_DEV_MEM     4'hA
`define SEP_DEV_CMD     4'h6
`define SEP_DEV_SENS    4'h3

// ****************************************************************
// command codes carried in select bits 3..1
// ****************************************************************
`define SEP_CODE_BLK0   3'h1
`define SEP_CODE_BLK1   3'h4
`define SEP_CODE_BLK2   3'h5
`define SEP_CODE_BLK3   3'h0
`define SEP_CODE_CLEAR  3'h3
`define SEP_CODE_LOWER  3'h6
`define SEP_CODE_UPPER  3'h7

// ****************************************************************
// array layout and reset values
// ****************************************************************
`define SEP_ERASED      8'hFF
`define SEP_MEM_WORDS   512
`define SEP_PAGE_BYTES  16
`define SEP_SENS_BYTES  2'h2
`define SEP_ADDR_RST    8'h00

// ****************************************************************
// timing
// ****************************************************************
`define SEP_CLK_NS      50
`define SEP_TW_NS       5000000

`endif

// *** hw/sep_pkg.sv ***
package sep_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEV,
    S_ADDR,
    S_DATA,
    S_ACK,
    S_TX,
    S_RACK
  } sep_state_e;

  typedef enum logic [1:0] {
    T_NONE,
    T_MEM,
    T_CMD,
    T_SENS
  } sep_tgt_e;

endpackage : sep_pkg

// *** hw/sep_evt_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface sep_evt_if;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;
  logic       sda;
  logic       hv;
  logic [2:0] logical_select_address;

  modport front (output start, stop, rise, fall, sda, hv, logical_select_address);
  modport core  (input  start, stop, rise, fall, sda, hv, logical_select_address);
endinterface : sep_evt_if

`default_nettype wire

// *** hw/sep_bus_front.sv ***
`timescale 1ns/10ps
`default_nettype none

module sep_bus_front (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       hv_i,
  input  wire logic [2:0] lsa_i,
  sep_evt_if.front        evt
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic [1:0] hv_sy_q;
  logic [2:0] lsa_m_q;
  logic [2:0] lsa_s_q;
  logic       scl_d_q;
  logic       sda_d_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      hv_sy_q  <= 2'h0;
      lsa_m_q  <= 3'h0;
      lsa_s_q  <= 3'h0;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      hv_sy_q  <= {hv_sy_q[0], hv_i};
      lsa_m_q  <= lsa_i;
      lsa_s_q  <= lsa_m_q;
    end
  end

  // previous synced levels for edge finding
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_sy_q[1];
      sda_d_q <= sda_sy_q[1];
    end
  end

  // ****************************************************************
  // bus conditions
  // ****************************************************************
  // start and stop need scl high in both samples, so a data edge
  // racing a clock edge is never taken as a condition
  assign evt.start = scl_sy_q[1] & scl_d_q & sda_d_q & ~sda_sy_q[1];
  assign evt.stop  = scl_sy_q[1] & scl_d_q & ~sda_d_q & sda_sy_q[1];
  assign evt.rise  = scl_sy_q[1] & ~scl_d_q;
  assign evt.fall  = ~scl_sy_q[1] & scl_d_q;
  assign evt.sda   = sda_sy_q[1];
  assign evt.hv    = hv_sy_q[1];
  assign evt.logical_select_address   = lsa_s_q;

endmodule : sep_bus_front

`default_nettype wire

// *** dv/sep_core_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module sep_core_checker #(
  parameter int unsigned P_TW_CYCLES = 20
) (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       busy_o,
  input wire logic       half_sel_o,
  input wire logic [3:0] block_protect_o,
  input wire logic       sens_wr_o
);
  // ****************
  // busy length
  // ****************
  // counter, since a repetition cannot reach the write time
  int unsigned cnt_q;
  always_ff @(posedge sys_clk_i) cnt_q <= busy_o ? cnt_q + 1 : 0;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_hold; busy_o [*8]; endsequence
  sequence s_quiet; !busy_o ##1 !busy_o; endsequence
  property p_hold; $rose(busy_o) |-> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("busy short");
  property p_len; $fell(busy_o) |-> cnt_q == P_TW_CYCLES; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_idle; $rose(busy_o) |-> scl_i && sda_i; endproperty
  a_idle: assert property (p_idle) else $error("busy off stop");
  property p_half; $changed(half_sel_o) |-> s_quiet; endproperty
  a_half: assert property (p_half) else $error("half busy");
  property p_prot; $changed(block_protect_o) |-> ##[0:4] busy_o; endproperty
  a_prot: assert property (p_prot) else $error("prot no busy");
  property p_one;
    $changed(block_protect_o) |-> block_protect_o == 4'h0 ||
      ($countones(block_protect_o & ~$past(block_protect_o)) == 1 &&
       (~block_protect_o & $past(block_protect_o)) == 4'h0);
  endproperty
  a_one: assert property (p_one) else $error("prot change");
  property p_pulse; sens_wr_o |=> !sens_wr_o; endproperty
  a_pulse: assert property (p_pulse) else $error("sensor pulse");
  property p_rst; $rose(rstn_i) |-> !half_sel_o && !busy_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule : sep_core_checker
bind sep_core sep_core_checker #(.P_TW_CYCLES(P_TW_CYCLES)) i_sep_core_checker (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
  .busy_o(busy_o), .half_sel_o(half_sel_o),
  .block_protect_o(block_protect_o), .sens_wr_o(sens_wr_o));
`default_nettype wire

// *** dv/sep_mst_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sep_mst_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // ****************
  // bus master, sda released high
  // ****************
  logic [8:0] obs;
  event       ev;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic w(int n);
    repeat (n) @(posedge clk_i);
  endtask : w
  // one phase: low half, rising scl, mid-high sda, sample, scl end level
  task automatic ph(input logic a, input logic c, input logic e,
                    output logic r);
    w(2);
    sda_o <= a;
    w(2);
    scl_o <= 1'h1;
    w(2);
    sda_o <= c;
    w(2);
    r = sda_i;
    scl_o <= e;
  endtask : ph
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      ph(d[i], d[i], 1'h0, r[i]);
    end
    obs = r;
    ->ev;
  endtask : xfer
endmodule : sep_mst_model
`default_nettype wire

// *** dv/sep_core_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sep_map.svh"
module sep_core_test;
  // ****************
  // bench
  // ****************
  logic        sys_clk_i, rstn_i, fac_n, hv;
  logic [2:0]  logical_select_address;
  logic [7:0]  dv, ad, mw, mr;
  logic [15:0] sd;
  logic [8:0]  q[$];
  logic [2:0]  cq[4];
  int          fails, total_checks, cyc, wrs;
  wire         scl, sda_m, oe_n, sda_d, busy, half, wr;
  wire  [3:0]  bp;
  wire  [7:0]  ptr;
  wire  [15:0] wd;
  wire         sda = sda_m & (oe_n | sda_d);
  sep_core #(.P_TW_CYCLES(200)) i_sep_core (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .factory_rstn_i(fac_n),
    .scl_i(scl), .sda_i(sda), .logical_select_address_i(logical_select_address),
    .select_pin_zero_hv_i(hv), .sens_rdata_i(sd), .sda_o(sda_d),
    .sda_oe_n_o(oe_n), .busy_o(busy), .half_sel_o(half),
    .block_protect_o(bp), .sens_wr_o(wr), .sens_ptr_o(ptr),
    .sens_wdata_o(wd));
  sep_mst_model i_sep_mst_model (.clk_i(sys_clk_i), .sda_i(sda),
    .scl_o(scl), .sda_o(sda_m));
  task automatic w(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : w
  task automatic s();
    logic r;
    i_sep_mst_model.ph(1'h1, 1'h0, 1'h0, r);
  endtask : s
  task automatic p();
    logic r;
    i_sep_mst_model.ph(1'h0, 1'h1, 1'h1, r);
    w(8);
  endtask : p
  // byte out or in; note carries bits seen and ninth bit
  task automatic t(logic [7:0] d, logic rd, logic a);
    logic [8:0] r;
    q.push_back({d, ~a});
    i_sep_mst_model.xfer({rd ? 8'hFF : d, rd ? ~a : 1'h1}, r);
  endtask : t
  task automatic ck(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : ck
  task automatic end_of_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(i_sep_mst_model.ev)
    ck("bus", q.pop_front(), i_sep_mst_model.obs);
  always @(posedge sys_clk_i) if (wr === 1'h1) wrs++;
  always @(posedge sys_clk_i) begin
    if (++cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    sys_clk_i = 1'h0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    void'($urandom(32'h90DB));
    rstn_i = 1'h0;
    fac_n = 1'h0;
    hv = 1'h0;
    logical_select_address = 3'($urandom);
    sd = 16'($urandom);
    dv = {1'h0, 7'($urandom)};
    ad = {1'h0, 7'($urandom)};
    mw = {`SEP_DEV_MEM, logical_select_address, 1'h0};
    mr = {`SEP_DEV_MEM, logical_select_address, 1'h1};
    cq = '{`SEP_CODE_BLK0, `SEP_CODE_BLK1, `SEP_CODE_BLK2, `SEP_CODE_BLK3};
    w(20);
    rstn_i <= 1'h1;
    fac_n <= 1'h1;
    w(10);
    s(); t(mw, 0, 1); t(ad, 0, 1); t(dv, 0, 1); p();
    s(); t(mw, 0, 0); p();
    ck("busy", 1, busy);
    w(250);
    s(); t(mr, 0, 1); t(`SEP_ERASED, 1, 0); p();
    s(); t(mw, 0, 1); t(ad, 0, 1); s(); t(mr, 0, 1);
    t(dv, 1, 1); t(`SEP_ERASED, 1, 0); p();
    hv <= 1'h1;
    s(); t({`SEP_DEV_CMD, `SEP_CODE_BLK0, 1'h0}, 0, 1);
    t(ad, 0, 1); t(dv, 0, 1); p();
    w(250);
    hv <= 1'h0;
    ck("prot", 1, bp);
    s(); t(mw, 0, 1); t(ad, 0, 1); t(~dv, 0, 0); p();
    ck("busy", 0, busy);
    s(); t(mr, 0, 1); t(dv, 1, 0); p();
    foreach (cq[i]) begin
      s(); t({`SEP_DEV_CMD, cq[i], 1'h1}, 0, i != 0);
      t(8'h00, 0, i != 0); t(8'h00, 0, i != 0); p();
    end
    s(); t({`SEP_DEV_CMD, `SEP_CODE_UPPER, 1'h0}, 0, 1); p();
    ck("half", 1, half);
    s(); t({`SEP_DEV_CMD, `SEP_CODE_LOWER, 1'h1}, 0, 0); p();
    rstn_i <= 1'h0;
    w(5);
    rstn_i <= 1'h1;
    w(10);
    ck("half", 0, half);
    ck("prot", 1, bp);
    s(); t({`SEP_DEV_CMD, `SEP_CODE_LOWER, 1'h1}, 0, 1); p();
    s(); t({`SEP_DEV_CMD, `SEP_CODE_LOWER, 1'h0}, 0, 1); p();
    hv <= 1'h1;
    s(); t({`SEP_DEV_CMD, `SEP_CODE_CLEAR, 1'h0}, 0, 1);
    t(ad, 0, 1); t(dv, 0, 1); p();
    w(250);
    hv <= 1'h0;
    ck("prot", 0, bp);
    s(); t({`SEP_DEV_MEM, ~logical_select_address, 1'h0}, 0, 0); p();
    s(); t({`SEP_DEV_SENS, logical_select_address, 1'h0}, 0, 1); t(ad, 0, 1);
    t(sd[15:8], 0, 1); t(sd[7:0], 0, 1); p();
    ck("sptr", {8'h00, ad}, {8'h00, ptr});
    ck("swd", sd, wd);
    ck("swr", 1, 16'(wrs));
    s(); t({`SEP_DEV_SENS, logical_select_address, 1'h1}, 0, 1);
    t(sd[15:8], 1, 1); t(sd[7:0], 1, 0); p();
    end_of_test();
  end
endmodule : sep_core_test
`default_nettype wire
